// file: verilog/slb_consts.svh
// Function
// (R1) Autobaud clock divides oscillator by 32/128/512
// (R2) Autobaud uses full 16-bit divisor counter
// (R3) Autobaud counter starts counting at one
// (R4) Wake plus autobaud measures byte after break
// (R5) Counter overflow before fifth edge sets flag
// (R6) Overflow keeps counting; fifth edge completes
// (R7) Data read clears flag; overflow software-clearable
// (R8) Overflow held while autobaud enable set
// (R9) Wake-on-break works only in asynchronous mode
// (R10) Wake enabled: reception off, watch falling edge
// (R11) Falling edge wake raises receive flag
// (R12) Rising edge ending break clears wake enable
// (R13) Nonzero character low time counts as wake
// (R14) Remote sends zero wake character, 10+ bits
// (R15) Break is start, twelve zeros, stop
// (R16) Send-break write starts break, data ignored
// (R17) Send-break clears after stop; preload follows
// (R18) Master sends break, dummy, then 55h sync
// (R19) Shift-empty status tracks break transmission too
// (R20) Received break: flag, framing error, 00h
// (R21) Synchronous mode: half-duplex, no start/stop
// (R22) Host mode select bits; receive enables choose
// (R23) Host drives clock, one clock per bit
// (R24) Autobaud holds idle; counts edges one to five
// (R25) Completion leaves period, clears autobaud enable
`ifndef SLB_CONSTS_SVH
`define SLB_CONSTS_SVH
`define SLB_ABD_DIV_FAST 16'h0020
`define SLB_ABD_DIV_MID 16'h0080
`define SLB_ABD_DIV_SLOW 16'h0200
`define SLB_ABD_START 16'h0001
`define SLB_ABD_EDGES 3'h5
`define SLB_BRK_ZEROS 4'hC
`define SLB_BITS 4'h8
`define SLB_FIFO_DEPTH 8
`endif

// file: verilog/slb_pkg.sv
`default_nettype none
package slb_pkg;
  typedef enum logic [2:0] {
    SLB_TX_IDLE,
    SLB_TX_START,
    SLB_TX_DATA,
    SLB_TX_STOP
  } slb_tx_e;
  typedef enum logic [1:0] {
    SLB_RX_IDLE,
    SLB_RX_START,
    SLB_RX_DATA,
    SLB_RX_STOP
  } slb_rx_e;
endpackage
`default_nettype wire

// file: verilog/slb_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface slb_fifo_if;
  logic [7:0] wdata;
  logic wvalid;
  logic wready;
  logic [7:0] rdata;
  logic rvalid;
  logic rready;
  modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid,
    input rready);
  modport user (output wdata, output wvalid, input wready, input rdata, input rvalid,
    output rready);
endinterface
`default_nettype wire

// file: verilog/slb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module slb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in, // Clock
  input wire logic srst_in, // Sync reset
  input wire logic ce_in, // Clock enable
  slb_fifo_if.fifo f // Buffer ports
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign f.wready = (cnt_q != (AW+1)'(DEPTH));
  assign f.rvalid = (cnt_q != '0);
  assign f.rdata = mem_q[rp_q];
  assign push = f.wvalid && f.wready;
  assign pop = f.rvalid && f.rready;
  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_q[wp_q] <= f.wdata;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce_in) begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  a_fifo_never_over: assert property (@(posedge clk_in) disable iff (srst_in)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// file: verilog/slb_lin_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "slb_consts.svh"
module slb_lin_port
  import slb_pkg::*;
(
  input wire logic clk_in, // System oscillator
  input wire logic srst_in, // Sync reset
  input wire logic ce_in, // Clock enable
  input wire logic port_enable_in, // Port on
  input wire logic sync_mode_in, // Synchronous select
  input wire logic clock_source_select_in, // Host clock
  input wire logic single_receive_enable_in, // One sync char
  input wire logic continuous_receive_enable_in, // Continuous sync
  input wire logic transmit_enable_in, // Transmit on
  input wire logic wide_divider_select_in, // 16-bit divider
  input wire logic high_speed_divider_select_in, // High speed
  input wire logic [15:0] divisor_in, // Divisor write value
  input wire logic divisor_wr_in, // Divisor write strobe
  input wire logic autobaud_set_in, // Set autobaud enable
  input wire logic autobaud_clr_in, // Clear autobaud enable
  input wire logic wake_set_in, // Set wake enable
  input wire logic wake_clr_in, // Clear wake enable
  input wire logic send_break_set_in, // Request break
  input wire logic ovf_clr_in, // Clear overflow flag
  input wire logic [7:0] tx_data_in, // Transmit data
  input wire logic tx_wr_in, // Transmit data write
  output logic tx_ready_out, // Buffer can take a byte
  input wire logic rx_rd_in, // Receive data read
  output logic [7:0] receive_data_out, // Receive data
  output logic receive_flag_out, // Receive flag
  output logic framing_error_flag_out, // Framing error
  output logic autobaud_enable_out, // Autobaud running
  output logic autobaud_overflow_flag_out, // Overflow
  output logic wake_on_break_enable_out, // Wake armed
  output logic send_break_request_out, // Break pending
  output logic shift_register_empty_out, // Transmit idle
  output logic transmit_buffer_flag_out, // Buffer empty
  output logic receive_idle_status_out, // Receiver idle
  output logic [15:0] divisor_out, // Divisor pair
  input wire logic rx_in, // Receive / data pin
  output logic tx_out, // Transmit pin level
  output logic data_out, // Sync data out
  output logic data_oe_out, // Sync data drive
  output logic sync_clock_line_out, // Sync clock out
  output logic sync_clock_line_oe_out // Sync clock drive
);
  // ****************************************
  // Input sync and clocking
  // ****************************************
  logic rx_m_q, rx_q, rx_prev_q;
  logic [15:0] div_q, brg_q, abd_pre_q, abd_lim;
  logic tick, rx_rise, rx_fall, async_on, host_on, abd_tick;
  slb_tx_e tx_st_q;
  slb_rx_e rx_st_q;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_m_q <= 1'b1;
      rx_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (ce_in) begin
      rx_m_q <= rx_in;
      rx_q <= rx_m_q;
      rx_prev_q <= rx_q;
    end
  end
  assign rx_rise = rx_q && !rx_prev_q;
  assign rx_fall = !rx_q && rx_prev_q;
  assign async_on = port_enable_in && !sync_mode_in;
  assign host_on = port_enable_in && sync_mode_in && clock_source_select_in; // R22
  always_comb begin
    abd_lim = `SLB_ABD_DIV_SLOW; // R1
    if (wide_divider_select_in && high_speed_divider_select_in) begin
      abd_lim = `SLB_ABD_DIV_FAST;
    end else if (wide_divider_select_in || high_speed_divider_select_in) begin
      abd_lim = `SLB_ABD_DIV_MID;
    end
  end
  assign tick = (brg_q == '0);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      brg_q <= '0;
    end else if (ce_in) begin
      brg_q <= !port_enable_in ? 16'h0000 : tick ? div_q : brg_q - 16'h0001;
    end
  end
  // ****************************************
  // Autobaud measurement
  // ****************************************
  logic abd_q, ovf_q, wake_q, flag_q, framing_error_flag_q;
  logic [2:0] edges_q;
  logic abd_live, abd_done, abd_carry;
  assign abd_live = abd_q && !wake_q && async_on; // R4
  assign abd_tick = (abd_pre_q == abd_lim - 16'h0001);
  assign abd_done = abd_live && rx_rise && (edges_q == `SLB_ABD_EDGES - 3'h1);
  assign abd_carry = abd_live && (edges_q != '0) && abd_tick && (div_q == 16'hFFFF);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      abd_pre_q <= '0;
    end else if (ce_in) begin
      abd_pre_q <= (!abd_live || edges_q == '0 || abd_tick) ? '0 : abd_pre_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      edges_q <= '0;
    end else if (ce_in) begin
      if (!abd_live || abd_done) begin
        edges_q <= '0;
      end else if (rx_rise) begin
        edges_q <= edges_q + 3'h1; // R24
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      div_q <= '0;
    end else if (ce_in) begin
      if (abd_live && rx_rise && edges_q == '0) begin
        div_q <= `SLB_ABD_START; // R3
      end else if (abd_live && edges_q != '0 && abd_tick) begin
        div_q <= div_q + 16'h0001; // R2 R6
      end else if (divisor_wr_in && !abd_q) begin
        div_q <= divisor_in;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      abd_q <= 1'b0;
    end else if (ce_in) begin
      if (abd_done || autobaud_clr_in) begin
        abd_q <= 1'b0; // R25
      end else if (autobaud_set_in) begin
        abd_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ovf_q <= 1'b0;
    end else if (ce_in) begin
      if (abd_carry) begin
        ovf_q <= 1'b1; // R5
      end else if (ovf_clr_in && !abd_q) begin
        ovf_q <= 1'b0; // R7 R8
      end
    end
  end
  a_abd_ovf_hold: assert property (@(posedge clk_in) disable iff (srst_in) // R8
    ce_in && ovf_q && abd_q |=> ovf_q) else $error("overflow lost while enabled");
  a_abd_done_clears: assert property (@(posedge clk_in) disable iff (srst_in) // R6
    ce_in && abd_done |=> !abd_q && flag_q) else $error("autobaud end wrong");
  // ****************************************
  // Wake on break and async receiver
  // ****************************************
  logic wake_rise, wake_fall;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q, rd_q;
  logic rx_got, rx_half;
  assign wake_fall = wake_q && async_on && rx_fall; // R9 R13
  assign wake_rise = wake_q && async_on && rx_rise; // R12
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wake_q <= 1'b0;
    end else if (ce_in) begin
      if (wake_rise || wake_clr_in) begin
        wake_q <= 1'b0;
      end else if (wake_set_in) begin
        wake_q <= 1'b1;
      end
    end
  end
  assign rx_half = (rx_cnt_q == {1'b0, div_q[15:1]});
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_st_q <= SLB_RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_got <= 1'b0;
    end else if (ce_in) begin
      rx_got <= 1'b0;
      if (!async_on || wake_q || abd_q) begin
        rx_st_q <= SLB_RX_IDLE; // R10 R24
      end else begin
        case (rx_st_q)
          SLB_RX_IDLE: begin
            rx_cnt_q <= '0;
            if (rx_fall) begin
              rx_st_q <= SLB_RX_START;
            end
          end
          SLB_RX_START: begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
            if (rx_half) begin
              rx_cnt_q <= '0;
              rx_bit_q <= '0;
              rx_st_q <= rx_q ? SLB_RX_IDLE : SLB_RX_DATA;
            end
          end
          SLB_RX_DATA: begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
            if (rx_cnt_q == div_q) begin
              rx_cnt_q <= '0;
              rx_sh_q <= {rx_q, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == `SLB_BITS - 4'h1) begin
                rx_st_q <= SLB_RX_STOP;
              end
            end
          end
          default: begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
            if (rx_cnt_q == div_q) begin
              rx_got <= 1'b1;
              rx_st_q <= SLB_RX_IDLE;
            end
          end
        endcase
      end
    end
  end
  // Stop sample taken in the same cycle rx_got rises, so read rx_q there
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      rd_q <= '0;
    end else if (ce_in) begin
      if (rx_got) begin
        rd_q <= rx_sh_q;
        framing_error_flag_q <= !rx_q; // R20
      end
      if (wake_fall || abd_done || rx_got) begin
        flag_q <= 1'b1; // R11
      end else if (rx_rd_in) begin
        flag_q <= 1'b0; // R7
      end
    end
  end
  a_wake_flag: assert property (@(posedge clk_in) disable iff (srst_in) // R11
    ce_in && wake_fall |=> flag_q) else $error("wake did not raise flag");
  a_wake_clears: assert property (@(posedge clk_in) disable iff (srst_in) // R12
    ce_in && wake_rise |=> !wake_q) else $error("wake enable not cleared");
  // ****************************************
  // Transmit path: FIFO, async shifter, sync host
  // ****************************************
  slb_fifo_if txf ();
  slb_fifo #(.WIDTH(8), .DEPTH(`SLB_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .f(txf)
  );
  logic sb_q, brk_q, tx_q, sck_q, half_q;
  logic [7:0] tsh_q;
  logic [3:0] tbit_q;
  logic rx_host;
  assign txf.wdata = tx_data_in;
  assign txf.wvalid = tx_wr_in && transmit_enable_in;
  assign tx_ready_out = txf.wready;
  assign rx_host = single_receive_enable_in || continuous_receive_enable_in;
  assign txf.rready = (tx_st_q == SLB_TX_IDLE) && tick && transmit_enable_in &&
    ((async_on) || (host_on && !rx_host));
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sb_q <= 1'b0;
    end else if (ce_in) begin
      if (brk_q && tx_st_q == SLB_TX_IDLE && tick) begin
        sb_q <= 1'b0; // R17
      end else if (send_break_set_in) begin
        sb_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_st_q <= SLB_TX_IDLE;
      tsh_q <= '0;
      tbit_q <= '0;
      brk_q <= 1'b0;
      tx_q <= 1'b1;
      sck_q <= 1'b0;
      half_q <= 1'b0;
    end else if (ce_in && tick) begin
      case (tx_st_q)
        SLB_TX_IDLE: begin
          tx_q <= 1'b1;
          sck_q <= 1'b0;
          half_q <= 1'b0;
          // Break marker lingers to the first idle tick so send-break clears after the stop bit
          brk_q <= 1'b0;
          if (txf.rready && txf.rvalid) begin
            brk_q <= sb_q && !brk_q && async_on;
            tsh_q <= (sb_q && !brk_q && async_on) ? 8'h00 : txf.rdata; // R16
            tbit_q <= '0;
            tx_st_q <= async_on ? SLB_TX_START : SLB_TX_DATA; // R21
          end
        end
        SLB_TX_START: begin
          tx_q <= 1'b0;
          tx_st_q <= SLB_TX_DATA;
        end
        SLB_TX_DATA: begin
          if (async_on) begin
            tx_q <= brk_q ? 1'b0 : tsh_q[0];
            tsh_q <= {1'b0, tsh_q[7:1]};
            tbit_q <= tbit_q + 4'h1;
            if (tbit_q == (brk_q ? `SLB_BRK_ZEROS : `SLB_BITS) - 4'h1) begin
              tx_st_q <= SLB_TX_STOP; // R15
            end
          end else begin
            half_q <= !half_q;
            sck_q <= !half_q; // R23
            if (!half_q) begin
              tx_q <= tsh_q[0];
              tsh_q <= {1'b0, tsh_q[7:1]};
            end else begin
              tbit_q <= tbit_q + 4'h1;
              if (tbit_q == `SLB_BITS - 4'h1) begin
                tx_st_q <= SLB_TX_IDLE;
              end
            end
          end
        end
        default: begin
          tx_q <= 1'b1;
          tx_st_q <= SLB_TX_IDLE;
        end
      endcase
    end
  end
  a_break_len: assert property (@(posedge clk_in) disable iff (srst_in) // R15
    brk_q && tx_st_q == SLB_TX_STOP |-> tbit_q == `SLB_BRK_ZEROS)
    else $error("break length wrong");
  a_shift_register_empty_busy: assert property (@(posedge clk_in) disable iff (srst_in) // R19
    tx_st_q != SLB_TX_IDLE |-> !shift_register_empty_out)
    else $error("shift empty during send");
  a_host_clk: assert property (@(posedge clk_in) disable iff (srst_in) // R22
    !host_on |-> !sync_clock_line_oe_out) else $error("clock driven outside host");
  // ****************************************
  // Outputs
  // ****************************************
  assign shift_register_empty_out = (tx_st_q == SLB_TX_IDLE); // R19
  assign transmit_buffer_flag_out = !txf.rvalid;
  assign receive_idle_status_out = (rx_st_q == SLB_RX_IDLE);
  assign receive_data_out = rd_q;
  assign receive_flag_out = flag_q;
  assign framing_error_flag_out = framing_error_flag_q;
  assign autobaud_enable_out = abd_q;
  assign autobaud_overflow_flag_out = ovf_q;
  assign wake_on_break_enable_out = wake_q;
  assign send_break_request_out = sb_q;
  assign divisor_out = div_q;
  assign tx_out = async_on ? tx_q : 1'b1;
  assign data_out = tx_q;
  assign data_oe_out = host_on && !rx_host;
  assign sync_clock_line_out = sck_q;
  assign sync_clock_line_oe_out = host_on;
endmodule
`default_nettype wire

// file: tb/slb_lin_node.sv
`timescale 1ns/1ps
`default_nettype none
module slb_lin_node (
  input wire logic clk_in, // Bench clock
  output logic rx_line_out, // Line into the port
  input wire logic tx_line_in // Port transmit line
);
  // ****************************************
  // Remote serial node, idle high, LSB first
  // ****************************************
  initial rx_line_out = 1'b1;

  // Line returns to its idle high level once the frame is over
  task automatic send_bits(input logic [15:0] bits, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      rx_line_out <= bits[i];
      repeat (bc) @(posedge clk_in);
    end
    rx_line_out <= 1'b1;
  endtask

  // Low time of the next frame on the port's line; 0 when nothing came
  task automatic low_len(output int n);
    int w;
    w = 0;
    n = 0;
    while (tx_line_in === 1'b1 && w < 30000) begin
      @(posedge clk_in);
      w++;
    end
    while (tx_line_in === 1'b0 && n < 30000 && w < 30000) begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // Mid-bit sampling; d[8] holds the stop bit, unknown if no frame came
  task automatic get_byte(input int bc, output logic [8:0] d);
    int w;
    w = 0;
    d = 'x;
    while (tx_line_in === 1'b1 && w < 30000) begin
      @(posedge clk_in);
      w++;
    end
    if (w < 30000) begin
      repeat (bc + bc / 2) @(posedge clk_in);
      for (int i = 0; i < 9; i++) begin
        d[i] = tx_line_in;
        repeat (bc) @(posedge clk_in);
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tb/serial_lin_break_autobaud_sync_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_lin_break_autobaud_sync_host_tb;
  logic clk_in, srst_in, ce, pen, syn, clock_source_select, single_receive_enable, continuous_receive_enable, transmit_enable, wide, hs;
  logic div_wr, abd_set, abd_clr, wk_set, wk_clr, brk_set, ovf_clr, tx_wr, rx_rd;
  logic rdy, rf, fe, abd, ovf, wk, sbr, sre, tbf, ridle, dat, dat_oe, sck, sck_oe, txo, rxl;
  logic [15:0] div_d, div_q;
  logic [7:0] tx_d, rx_d;
  int err_total, cmp_count;

  slb_lin_port DUT (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce), .port_enable_in(pen),
    .sync_mode_in(syn), .clock_source_select_in(clock_source_select), .single_receive_enable_in(single_receive_enable),
    .continuous_receive_enable_in(continuous_receive_enable), .transmit_enable_in(transmit_enable),
    .wide_divider_select_in(wide), .high_speed_divider_select_in(hs), .divisor_in(div_d),
    .divisor_wr_in(div_wr), .autobaud_set_in(abd_set), .autobaud_clr_in(abd_clr),
    .wake_set_in(wk_set), .wake_clr_in(wk_clr), .send_break_set_in(brk_set),
    .ovf_clr_in(ovf_clr), .tx_data_in(tx_d), .tx_wr_in(tx_wr), .tx_ready_out(rdy),
    .rx_rd_in(rx_rd), .receive_data_out(rx_d), .receive_flag_out(rf),
    .framing_error_flag_out(fe), .autobaud_enable_out(abd),
    .autobaud_overflow_flag_out(ovf), .wake_on_break_enable_out(wk),
    .send_break_request_out(sbr), .shift_register_empty_out(sre),
    .transmit_buffer_flag_out(tbf), .receive_idle_status_out(ridle), .divisor_out(div_q),
    .rx_in(rxl), .tx_out(txo), .data_out(dat), .data_oe_out(dat_oe),
    .sync_clock_line_out(sck), .sync_clock_line_oe_out(sck_oe));

  slb_lin_node node (.clk_in(clk_in), .rx_line_out(rxl), .tx_line_in(txo));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Edge timing against the prescaler phase leaves one count of slack
  function automatic logic near(input logic [15:0] v, input int e, input int t);
    return (v >= e - t && v <= e + t);
  endfunction

  task automatic pulse(input int k);
    @(negedge clk_in);
    case (k)
      0: abd_set = 1'b1;
      1: abd_clr = 1'b1;
      2: wk_set = 1'b1;
      3: brk_set = 1'b1;
      4: ovf_clr = 1'b1;
      5: tx_wr = 1'b1;
      6: rx_rd = 1'b1;
      default: div_wr = 1'b1;
    endcase
    @(negedge clk_in);
    {div_wr, abd_set, abd_clr, wk_set, brk_set, ovf_clr, tx_wr, rx_rd} = '0;
  endtask

  task automatic wait_rf;
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
      if (n > 20000) begin
        err_total++;
        stop_test();
      end
    end while (rf !== 1'b1);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_autobaud;
    int nd;
    for (int k = 0; k < 4; k++) begin
      nd = (k == 0) ? 32 : (k == 3) ? 512 : 128;
      @(negedge clk_in);
      {wide, hs} = 2'(3 - k);
      pulse(0);
      pulse(4);
      // Sync byte at two counter periods a bit: 16 counts plus the start at one
      node.send_bits(16'h02AA, 10, 2 * nd);
      wait_rf();
      chk("abd div", {15'h0, near(div_q, 17, 1)}, 16'h0001);
      chk("abd enable", {15'h0, abd}, 16'h0000);
      chk("abd ovf", {15'h0, ovf}, 16'h0000);
      pulse(6);
      chk("abd flag rd", {15'h0, rf}, 16'h0000);
    end
    pulse(0);
    pulse(1);
    chk("abd abort", {15'h0, abd}, 16'h0000);
    $display("test autobaud done");
  endtask

  task automatic t_wake;
    @(negedge clk_in);
    {wide, hs} = 2'b11;
    pulse(2);
    pulse(0);
    fork
      node.send_bits(16'h2000, 14, 64);
      begin
        repeat (30) @(negedge clk_in);
        chk("wake flag", {15'h0, rf}, 16'h0001);
        chk("wake held", {15'h0, wk}, 16'h0001);
        chk("wake rx idle", {15'h0, ridle}, 16'h0001);
        chk("abd waits", {15'h0, abd}, 16'h0001);
      end
    join
    chk("wake clear", {15'h0, wk}, 16'h0000);
    chk("wake no framing_error_flag", {15'h0, fe}, 16'h0000);
    pulse(6);
    chk("wake flag rd", {15'h0, rf}, 16'h0000);
    node.send_bits(16'h02AA, 10, 64);
    wait_rf();
    chk("wake abd div", {15'h0, near(div_q, 17, 1)}, 16'h0001);
    chk("wake abd end", {15'h0, abd}, 16'h0000);
    pulse(6);
    $display("test wake done");
  endtask

  task automatic t_brk_rx;
    pulse(7);
    node.send_bits(16'h2000, 14, 16);
    wait_rf();
    chk("brk rx framing_error_flag", {15'h0, fe}, 16'h0001);
    chk("brk rx data", {8'h0, rx_d}, 16'h0000);
    pulse(6);
    $display("test break receive done");
  endtask

  task automatic t_brk_tx;
    int n;
    logic [8:0] d;
    pulse(3);
    fork
      node.low_len(n);
      begin
        tx_d = 8'hA5;
        pulse(5);
        tx_d = 8'h55;
        pulse(5);
        repeat (20) @(negedge clk_in);
        chk("brk busy", {15'h0, sre}, 16'h0000);
        chk("brk pending", {15'h0, sbr}, 16'h0001);
      end
    join
    chk("brk low", {15'h0, near(16'(n), 208, 1)}, 16'h0001);
    node.get_byte(16, d);
    chk("brk cleared", {15'h0, sbr}, 16'h0000);
    chk("sync byte", {7'h0, d}, 16'h0155);
    repeat (20) @(negedge clk_in);
    chk("tx idle", {15'h0, sre}, 16'h0001);
    chk("buf empty", {15'h0, tbf}, 16'h0001);
    $display("test break transmit done");
  endtask

  task automatic t_sync;
    int r, f;
    logic [7:0] sh;
    logic p;
    @(negedge clk_in);
    syn = 1'b1;
    clock_source_select = 1'b1;
    continuous_receive_enable = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("host clk oe", {15'h0, sck_oe}, 16'h0001);
    tx_d = 8'hC3;
    pulse(5);
    r = 0;
    f = 0;
    sh = 8'h00;
    p = sck;
    repeat (600) begin
      @(negedge clk_in);
      if (sck === 1'b1 && p === 1'b0) r++;
      if (sck === 1'b0 && p === 1'b1) begin
        sh = {dat, sh[7:1]};
        f++;
      end
      p = sck;
    end
    chk("host clocks", 16'(r), 16'h0008);
    chk("host data", {8'h0, sh}, 16'h00C3);
    chk("host data oe", {15'h0, dat_oe}, 16'h0001);
    single_receive_enable = 1'b1;
    @(negedge clk_in);
    chk("host rx oe", {15'h0, dat_oe}, 16'h0000);
    chk("host rx clk oe", {15'h0, sck_oe}, 16'h0001);
    $display("test sync host done");
  endtask

  initial begin
    {srst_in, ce, pen, continuous_receive_enable, transmit_enable, wide, hs} = 7'h7F;
    {syn, clock_source_select, single_receive_enable, wk_clr} = 4'h0;
    {div_wr, abd_set, abd_clr, wk_set, brk_set, ovf_clr, tx_wr, rx_rd} = '0;
    div_d = 16'h000F;
    tx_d = 8'h00;
    err_total = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk_in);
    srst_in = 1'b0;
    @(negedge clk_in);
    chk("div reset", div_q, 16'h0000);
    chk("tx reset", {15'h0, txo}, 16'h0001);
    chk("buf ready", {15'h0, rdy}, 16'h0001);
    chk("rx idle", {15'h0, ridle}, 16'h0001);
    t_autobaud();
    t_wake();
    t_brk_rx();
    t_brk_tx();
    t_sync();
    stop_test();
  end
endmodule
`default_nettype wire
